// File: rtl/sdcr_consts.vh
// constants for the shadow/dram configuration register bank
// assumes word-aligned axi4-lite access, byte address = 4 x index
`ifndef SDCR_CONSTS_VH
`define SDCR_CONSTS_VH
`define SDCR_IDX_UPPER     8'h23
`define SDCR_IDX_DRAM1     8'h24
`define SDCR_IDX_DRAM2     8'h25
`define SDCR_IDX_CTRL      8'h26
`define SDCR_IDX_STAT      8'h27
`define SDCR_RST_UPPER     8'h00
`define SDCR_RST_DRAM1     8'h08
`define SDCR_RST_DRAM2     8'h70
`define SDCR_RST_CTRL      8'h00
`define SDCR_D1_REMAP      7
`define SDCR_D1_PAR2       3
`define SDCR_D2_PINSEL     7
`define SDCR_D2_RDWS_HI    6
`define SDCR_D2_RDWS_LO    5
`define SDCR_D2_WRWS       4
`define SDCR_D2_FLUSH      3
`define SDCR_D2_DIR_SUP    2
`define SDCR_D2_DIV_HI     1
`define SDCR_D2_DIV_LO     0
`define SDCR_CT_CMOD_EN    0
`define SDCR_CT_WRFAST     1
`define SDCR_CT_ADSDLY     2
`define SDCR_RD_3222       2'b00
`define SDCR_RD_4333       2'b10
`define SDCR_RD_5444       2'b11
`define SDCR_DIV6          2'b00
`define SDCR_DIV5          2'b01
`define SDCR_DIV4          2'b10
`define SDCR_DIV3          2'b11
`define SDCR_PORT_KBD_DATA 16'h0060
`define SDCR_PORT_KBD_CMD  16'h0064
`define SDCR_PORT_RTC_IDX  16'h0070
`define SDCR_PORT_RTC_DAT  16'h0071
`define SDCR_RESP_OKAY     2'b00
`define SDCR_RESP_SLVERR   2'b10
`endif

// File: rtl/sdcr_clkdiv.v
// expansion-bus clock divider, divide by 3..6
// assumes divisor select is quasi-static; a change applies at once, inside the current period
`timescale 1ns/100ps
module sdcr_clkdiv (
	input  wire       clk_i,
	input  wire       nrst_i,
	input  wire [1:0] sel_i,
	output reg        bus_clk_o
);
	reg  [2:0] cnt_r;
	reg  [2:0] last;
	wire [2:0] half;
	always @* begin
		case (sel_i)
			2'b00:   last = 3'd5;
			2'b01:   last = 3'd4;
			2'b10:   last = 3'd3;
			default: last = 3'd2;
		endcase
	end
	// high for the first half (floor) of the period; odd ratios are not 50/50
	assign half = (last + 3'd1) >> 1;
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_r     <= 3'd0;
			bus_clk_o <= 1'b0;
		end else begin
			cnt_r     <= (cnt_r >= last) ? 3'd0 : cnt_r + 3'd1;
			bus_clk_o <= ((cnt_r >= last) ? 3'd0 : cnt_r + 3'd1) < half;
		end
	end
endmodule

// File: rtl/sdcr_regs.v
// shadow ram segment and dram configuration register bank, axi4-lite slave
// assumes synchronous inputs on clk_i; power-good rising edge is sampled here
//
// Behaviour
// R1: four bits enable shadow ram per 16KB block of E segment, else isa
// R2: bit7 EC000, bit6 E8000, bit5 E4000, bit4 E0000; reset zero
// R3: four bits enable shadow ram per 16KB block of D segment, else isa
// R4: bit3 DC000, bit2 D8000, bit1 D4000, bit0 D0000; reset zero
// R5: remap bit redirects overlay accesses to A0000/B0000; reset clear
// R6: two 3-bit legacy dram config fields at 6:4 and 2:0, reset 000
// R7: byte-2 parity checked only while its bit is set; reset one
// R8: strap low at power-good rise lets register bit pick shared pin function
// R9: read burst: 00 3-2-2-2, 10 4-3-3-3, 11 5-4-4-4 default
// R10: write bit one gives 4-3-3-3 (reset), zero gives 3-clock first write
// R11: with write bit zero, another control bit picks 3-3-3-3 or 3-2-2-2
// R12: flush bit 0-to-1 gives one-clock low flush pulse when module enabled
// R13: flush bit never self-clears; software writes zero to rearm
// R14: suppress bit hides transceiver direction on ports 60h,64h,70h,71h
// R15: expansion clock divisor 00 /6, 01 /5, 10 /4, 11 /3; reset 00
// R16: with divide-by-6, address strobe delayed one clock per control bit
// R17: all fields read back last write and load defaults at reset
`timescale 1ns/100ps
`include "sdcr_consts.vh"
module sdcr_regs (
	input  wire        clk_i,
	input  wire        nrst_i,
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        power_good_in_i,
	input  wire        config_strap_pin_i,
	input  wire        mem_dir_req_i,
	input  wire        local_mem_req_i,
	input  wire        xcvr_dir_req_i,
	input  wire [15:0] io_port_addr_i,
	input  wire        io_cycle_i,
	input  wire        cpu_address_strobe_n_i,
	input  wire        byte2_parity_err_i,
	output wire [7:0]  shadow_enable_o,
	output wire        system_mgmt_remap_o,
	output wire [5:0]  dram_config_o,
	output reg         byte2_parity_err_o,
	output reg         shared_pin_n_o,
	output wire [1:0]  read_burst_o,
	output wire        write_first3_o,
	output wire        write_burst_fast_o,
	output reg         cache_module_flush_n_o,
	output reg         transceiver_dir_n_o,
	output wire        expansion_bus_clock_o,
	output reg         cpu_address_strobe_n_o
);
	reg  [7:0] upper_r;
	reg  [7:0] dram1_r;
	reg  [7:0] dram2_r;
	reg  [7:0] ctrl_r;
	reg  [31:0] awaddr_r;
	reg  [31:0] wdata_r;
	reg  [3:0]  wstrb_r;
	reg         aw_held_r;
	reg         w_held_r;
	reg         pg_d_r;
	reg         strap_low_r;
	reg         strobe_d_r;
	wire        wr_go;
	wire [7:0]  wr_idx;
	wire [7:0]  rd_idx;
	wire        wr_lane;
	wire [7:0]  wbyte;
	wire        flush_new;
	wire        legacy_port;
	wire        rd_ok;
	wire        wr_ok;
	reg  [7:0]  rd_byte;
	reg  [7:0]  upper_nxt;
	reg  [7:0]  dram1_nxt;
	reg  [7:0]  dram2_nxt;
	reg  [7:0]  ctrl_nxt;
	wire [7:0]  shadow_bits;
	wire [1:0]  div_sel;
	wire        pin_sel;
	wire        dir_sup;
	wire        flush_bit;
	wire        par2_en;
	wire        cmod_en;
	wire        wr_fast_sel;
	wire        strobe_dly_en;
	wire        pg_rise;
	wire        strobe_slow;

	// address and data latch independently so either may arrive first
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go   = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wr_idx  = awaddr_r[9:2];
	assign wr_lane = wstrb_r[0];
	assign wbyte   = wdata_r[7:0];
	assign rd_idx  = s_axi_araddr[9:2];
	assign wr_ok   = (awaddr_r[31:10] == 22'd0) && (awaddr_r[1:0] == 2'b00) &&
	                 (wr_idx == `SDCR_IDX_UPPER || wr_idx == `SDCR_IDX_DRAM1 ||
	                  wr_idx == `SDCR_IDX_DRAM2 || wr_idx == `SDCR_IDX_CTRL);
	assign rd_ok   = (s_axi_araddr[31:10] == 22'd0) && (s_axi_araddr[1:0] == 2'b00) &&
	                 (rd_idx == `SDCR_IDX_UPPER || rd_idx == `SDCR_IDX_DRAM1 ||
	                  rd_idx == `SDCR_IDX_DRAM2 || rd_idx == `SDCR_IDX_CTRL ||
	                  rd_idx == `SDCR_IDX_STAT);

	// write address half; freed once the pair has been used
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aw_held_r <= 1'b0;
			awaddr_r  <= 32'h0000_0000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			awaddr_r  <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end
	end

	// write data half
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			w_held_r <= 1'b0;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			wdata_r  <= s_axi_wdata;
			wstrb_r  <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end
	end

	// write response; both halves stay refused until it is taken
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SDCR_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_ok ? `SDCR_RESP_OKAY : `SDCR_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// next register values; only byte lane 0 carries data, other lanes are dropped
	always @* begin
		upper_nxt = upper_r;
		dram1_nxt = dram1_r;
		dram2_nxt = dram2_r;
		ctrl_nxt  = ctrl_r;
		if (wr_go && wr_ok && wr_lane) begin
			case (wr_idx)
				`SDCR_IDX_UPPER: upper_nxt = wbyte; // [R17]
				`SDCR_IDX_DRAM1: dram1_nxt = wbyte; // [R17]
				`SDCR_IDX_DRAM2: dram2_nxt = wbyte; // [R13] [R17]
				`SDCR_IDX_CTRL:  ctrl_nxt  = wbyte;
				default:         ctrl_nxt  = ctrl_r;
			endcase
		end
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			upper_r <= `SDCR_RST_UPPER; // [R2] [R4] [R17]
		end else begin
			upper_r <= upper_nxt;
		end
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dram1_r <= `SDCR_RST_DRAM1; // [R5] [R6] [R7] [R17]
		end else begin
			dram1_r <= dram1_nxt;
		end
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dram2_r <= `SDCR_RST_DRAM2; // [R9] [R10] [R15] [R17]
		end else begin
			dram2_r <= dram2_nxt;
		end
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_r <= `SDCR_RST_CTRL;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	always @* begin
		case (rd_idx)
			`SDCR_IDX_UPPER: rd_byte = upper_r; // [R17]
			`SDCR_IDX_DRAM1: rd_byte = dram1_r;
			`SDCR_IDX_DRAM2: rd_byte = dram2_r;
			`SDCR_IDX_CTRL:  rd_byte = ctrl_r;
			`SDCR_IDX_STAT:  rd_byte = {6'd0, byte2_parity_err_o, strap_low_r};
			default:         rd_byte = 8'h00;
		endcase
	end

	// valid and payload kept apart: payload only moves on an accepted request
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_axi_rvalid <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SDCR_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rdata <= rd_ok ? {24'd0, rd_byte} : 32'h0000_0000;
			s_axi_rresp <= rd_ok ? `SDCR_RESP_OKAY : `SDCR_RESP_SLVERR;
		end
	end

	// named field views keep the output logic readable
	assign div_sel       = dram2_r[`SDCR_D2_DIV_HI:`SDCR_D2_DIV_LO];
	assign pin_sel       = dram2_r[`SDCR_D2_PINSEL];
	assign dir_sup       = dram2_r[`SDCR_D2_DIR_SUP];
	assign flush_bit     = dram2_r[`SDCR_D2_FLUSH];
	assign par2_en       = dram1_r[`SDCR_D1_PAR2];
	assign cmod_en       = ctrl_r[`SDCR_CT_CMOD_EN];
	assign wr_fast_sel   = ctrl_r[`SDCR_CT_WRFAST];
	assign strobe_dly_en = ctrl_r[`SDCR_CT_ADSDLY];
	assign pg_rise       = power_good_in_i && !pg_d_r;
	assign strobe_slow   = (div_sel == `SDCR_DIV6) && strobe_dly_en;

	// one enable per 16KB sub-block: bits 7:4 the E segment, bits 3:0 the D segment
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_shadow
			assign shadow_bits[gi] = upper_r[gi]; // [R1] [R2] [R3] [R4]
		end
	endgenerate

	assign shadow_enable_o     = shadow_bits; // [R1] [R3]
	assign system_mgmt_remap_o = dram1_r[`SDCR_D1_REMAP]; // [R5]
	assign dram_config_o       = {dram1_r[6:4], dram1_r[2:0]}; // [R6]
	assign read_burst_o        = dram2_r[`SDCR_D2_RDWS_HI:`SDCR_D2_RDWS_LO]; // [R9]
	assign write_first3_o      = !dram2_r[`SDCR_D2_WRWS]; // [R10]
	// fast 3-2-2-2 only when the 3-clock first write is chosen
	assign write_burst_fast_o  = write_first3_o && wr_fast_sel; // [R11]

	// write data is taken directly so a 0->1 write fires in the write cycle
	assign flush_new   = wr_go && wr_ok && wr_lane && (wr_idx == `SDCR_IDX_DRAM2) &&
	                     wbyte[`SDCR_D2_FLUSH] && !flush_bit;
	assign legacy_port = io_cycle_i &&
	                     (io_port_addr_i == `SDCR_PORT_KBD_DATA ||
	                      io_port_addr_i == `SDCR_PORT_KBD_CMD ||
	                      io_port_addr_i == `SDCR_PORT_RTC_IDX ||
	                      io_port_addr_i == `SDCR_PORT_RTC_DAT);

	// edge detector starts low, so power-good already high at release counts as a rise
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pg_d_r      <= 1'b0;
			strap_low_r <= 1'b0;
		end else begin
			pg_d_r <= power_good_in_i;
			// strap caught once on the rising edge of power-good
			if (pg_rise) begin
				strap_low_r <= !config_strap_pin_i; // [R8]
			end
		end
	end

	// one-clock low pulse; the control bit itself is left alone
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cache_module_flush_n_o <= 1'b1;
		end else begin
			cache_module_flush_n_o <= !(flush_new && cmod_en); // [R12]
		end
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			byte2_parity_err_o <= 1'b0;
		end else begin
			byte2_parity_err_o <= byte2_parity_err_i && par2_en; // [R7]
		end
	end

	// without the strap the pin stays on the memory direction function
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			shared_pin_n_o <= 1'b1;
		end else if (strap_low_r && pin_sel) begin
			shared_pin_n_o <= !local_mem_req_i; // [R8]
		end else begin
			shared_pin_n_o <= !mem_dir_req_i; // [R8]
		end
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			transceiver_dir_n_o <= 1'b1;
		end else begin
			transceiver_dir_n_o <= !(xcvr_dir_req_i && !(legacy_port && dir_sup)); // [R14]
		end
	end

	// registered path costs one clock; delayed variant costs two
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			strobe_d_r             <= 1'b1;
			cpu_address_strobe_n_o <= 1'b1;
		end else begin
			strobe_d_r <= cpu_address_strobe_n_i;
			if (strobe_slow) begin
				cpu_address_strobe_n_o <= strobe_d_r; // [R16]
			end else begin
				cpu_address_strobe_n_o <= cpu_address_strobe_n_i;
			end
		end
	end

	sdcr_clkdiv u_div (
		.clk_i     (clk_i),
		.nrst_i    (nrst_i),
		.sel_i     (div_sel), // [R15]
		.bus_clk_o (expansion_bus_clock_o)
	);
endmodule

// File: sim/sdcr_regs_monitor.sv
// assertion checker for the shadow/dram register bank
// assumes it is bound to sdcr_regs and sees only its ports
`timescale 1ns/100ps
module sdcr_regs_monitor (
	input wire        clk_i,
	input wire        nrst_i,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        byte2_parity_err_i,
	input wire        byte2_parity_err_o,
	input wire        write_first3_o,
	input wire        write_burst_fast_o,
	input wire        cache_module_flush_n_o,
	input wire        xcvr_dir_req_i,
	input wire [15:0] io_port_addr_i,
	input wire        transceiver_dir_n_o,
	input wire        expansion_bus_clock_o,
	input wire        cpu_address_strobe_n_i,
	input wire        cpu_address_strobe_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_flush_fall;
		$fell(cache_module_flush_n_o);
	endsequence
	a_flush_one_clk: assert property (s_flush_fall |=> cache_module_flush_n_o)
		else $error("flush low too long");
	a_flush_after_wr: assert property (s_flush_fall |-> s_axi_bvalid)
		else $error("flush without a write");
	a_fast_needs_3: assert property (write_burst_fast_o |-> write_first3_o)
		else $error("fast write without short first write");
	a_dir_normal: assert property (xcvr_dir_req_i && io_port_addr_i[3:0] == 4'h8
		|=> !transceiver_dir_n_o) else $error("direction not asserted");
	a_dir_idle: assert property (!xcvr_dir_req_i |=> transceiver_dir_n_o)
		else $error("direction without request");
	a_bus_clk_high: assert property ($rose(expansion_bus_clock_o)
		|-> ##[1:3] $fell(expansion_bus_clock_o)) else $error("bus clock high time");
	a_strobe_lag: assert property ($fell(cpu_address_strobe_n_o)
		|-> !$past(cpu_address_strobe_n_i) || !$past(cpu_address_strobe_n_i, 2))
		else $error("strobe lag");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read answer");
	a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer stuck");
	a_parity_gate: assert property (!byte2_parity_err_i |=> !byte2_parity_err_o)
		else $error("parity error without cause");
endmodule
bind sdcr_regs sdcr_regs_monitor u_sdcr_regs_monitor (.*);

// File: sim/testbench.sv
// self-checking bench for the shadow/dram register bank
// assumes the bench alone drives every pin of sdcr_regs
`timescale 1ns/100ps
`include "sdcr_consts.vh"
module testbench;
	localparam [31:0] A_UP = 32'h8c, A_D1 = 32'h90, A_D2 = 32'h94, A_CT = 32'h98;
	reg         clk_i, nrst_i, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
	reg         power_good_in_i, config_strap_pin_i, mem_dir_req_i, local_mem_req_i;
	reg         xcvr_dir_req_i, io_cycle_i, cpu_address_strobe_n_i, byte2_parity_err_i;
	reg  [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, rdat;
	reg  [15:0] io_port_addr_i;
	reg  [1:0]  rsp;
	wire [3:0]  s_axi_wstrb = 4'h1;
	wire        s_axi_bready = 1'b1;
	wire        s_axi_rready = 1'b1;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp, read_burst_o;
	wire [31:0] s_axi_rdata;
	wire [7:0]  shadow_enable_o;
	wire [5:0]  dram_config_o;
	wire        system_mgmt_remap_o, byte2_parity_err_o, shared_pin_n_o, write_first3_o;
	wire        write_burst_fast_o, cache_module_flush_n_o, transceiver_dir_n_o;
	wire        expansion_bus_clock_o, cpu_address_strobe_n_o;
	integer     n_fail, comparisons, n_flush, i, n;
	sdcr_regs u_sdcr_regs (.*);
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(negedge clk_i) if (cache_module_flush_n_o === 1'b0) n_flush = n_flush + 1;
	task final_report;
		begin
			if (n_fail == 0 && comparisons > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// all requests start after a rising edge; answers are sampled at the falling edge,
	// where the combinational readies already hold their value for the next edge
	task wr(input [31:0] a, input [7:0] d);
		reg ha, hw, hb;
		begin
			@(posedge clk_i);
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h000000, d};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			hb = 1'b0;
			while (!hb) begin
				@(negedge clk_i);
				ha = s_axi_awvalid & s_axi_awready;
				hw = s_axi_wvalid & s_axi_wready;
				hb = s_axi_bvalid;
				rsp = s_axi_bresp;
				if (!hb) begin
					@(posedge clk_i);
					if (ha) s_axi_awvalid <= 1'b0;
					if (hw) s_axi_wvalid <= 1'b0;
				end
			end
		end
	endtask
	task rd(input [31:0] a);
		reg ha, hr;
		begin
			@(posedge clk_i);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			hr = 1'b0;
			while (!hr) begin
				@(negedge clk_i);
				ha = s_axi_arvalid & s_axi_arready;
				hr = s_axi_rvalid;
				rdat = s_axi_rdata;
				rsp = s_axi_rresp;
				if (!hr) begin
					@(posedge clk_i);
					if (ha) s_axi_arvalid <= 1'b0;
				end
			end
		end
	endtask
	task rchk(input [31:0] a, input [7:0] e);
		begin
			rd(a);
			chk(rdat, {24'h000000, e});
			chk(rsp, `SDCR_RESP_OKAY);
		end
	endtask
	task per;
		reg p;
		begin
			@(posedge expansion_bus_clock_o);
			@(negedge clk_i);
			n = 0;
			do begin
				p = expansion_bus_clock_o;
				@(negedge clk_i);
				n = n + 1;
			end while (!(expansion_bus_clock_o && !p));
		end
	endtask
	task lag;
		begin
			@(posedge clk_i);
			cpu_address_strobe_n_i <= 1'b0;
			@(posedge clk_i);
			cpu_address_strobe_n_i <= 1'b1;
			n = 0;
			do begin
				@(negedge clk_i);
				n = n + 1;
			end while (cpu_address_strobe_n_o !== 1'b0 && n < 6);
		end
	endtask
	initial begin
		{nrst_i, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, power_good_in_i} = 5'h00;
		{config_strap_pin_i, mem_dir_req_i, local_mem_req_i, xcvr_dir_req_i} = 4'h0;
		{io_cycle_i, byte2_parity_err_i, io_port_addr_i} = 18'h00000;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		cpu_address_strobe_n_i = 1'b1;
		{n_fail, comparisons, n_flush} = 96'h0;
		repeat (5) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		power_good_in_i <= 1'b1; // strap held low at the power-good rise
		rchk(A_UP, 8'h00);
		rchk(A_D1, 8'h08);
		rchk(A_D2, 8'h70);
		for (i = 0; i < 8; i = i + 1) begin
			wr(A_UP, 8'h01 << i);
			chk(shadow_enable_o, 32'h1 << i);
		end
		rchk(A_UP, 8'h80);
		wr(A_D1, 8'hf7);
		chk({system_mgmt_remap_o, dram_config_o}, 7'h7f);
		@(posedge clk_i) byte2_parity_err_i <= 1'b1;
		repeat (2) @(negedge clk_i);
		chk(byte2_parity_err_o, 1'b0);
		wr(A_D1, 8'h08);
		@(negedge clk_i);
		chk({byte2_parity_err_o, system_mgmt_remap_o}, 2'b10);
		for (i = 0; i < 3; i = i + 1) begin
			wr(A_D2, {1'b0, i != 0, i == 2, 5'h10});
			chk(read_burst_o, {i != 0, i == 2});
		end
		chk(write_first3_o, 1'b0);
		wr(A_D2, 8'h60);
		wr(A_CT, 8'h02);
		chk({write_first3_o, write_burst_fast_o}, 2'b11);
		wr(A_D2, 8'h70);
		chk({write_first3_o, write_burst_fast_o}, 2'b00);
		for (i = 0; i < 4; i = i + 1) begin
			wr(A_D2, 8'h70 | i);
			per;
			per;
			chk(n, 6 - i);
		end
		wr(A_D2, 8'h70);
		lag;
		chk(n, 1);
		wr(A_CT, 8'h04);
		lag;
		chk(n, 2);
		wr(A_D2, 8'h71);
		lag;
		chk(n, 1);
		i = n_flush;
		wr(A_D2, 8'h78); // no pulse while module support is off
		wr(A_D2, 8'h70);
		wr(A_CT, 8'h01);
		wr(A_D2, 8'h78);
		repeat (3) @(negedge clk_i);
		chk(n_flush - i, 1);
		wr(A_D2, 8'h78);
		rchk(A_D2, 8'h78);
		wr(A_D2, 8'h70);
		wr(A_D2, 8'h78);
		repeat (3) @(negedge clk_i);
		chk(n_flush - i, 2);
		wr(A_D2, 8'h74);
		@(posedge clk_i) {xcvr_dir_req_i, io_cycle_i} <= 2'b11;
		for (n = 0; n < 6; n = n + 1) begin
			if (n == 5) wr(A_D2, 8'h70);
			@(posedge clk_i);
			io_port_addr_i <= (n == 1) ? 16'h0064 : (n == 2) ? 16'h0070 :
			                  (n == 3) ? 16'h0071 : (n == 4) ? 16'h0068 : 16'h0060;
			repeat (2) @(negedge clk_i);
			chk(transceiver_dir_n_o, n < 4);
		end
		wr(A_D2, 8'hf0);
		@(posedge clk_i) {xcvr_dir_req_i, local_mem_req_i} <= 2'b01;
		repeat (2) @(negedge clk_i);
		chk(shared_pin_n_o, 1'b0);
		wr(A_D2, 8'h70);
		chk(rsp, `SDCR_RESP_OKAY);
		@(negedge clk_i);
		chk(shared_pin_n_o, 1'b1);
		rchk(32'h9c, 8'h03);
		wr(32'h100, 8'h55);
		chk(rsp, `SDCR_RESP_SLVERR);
		rd(32'h100);
		chk(rsp, `SDCR_RESP_SLVERR);
		chk(rdat, 32'h0);
		final_report;
	end
	initial begin
		#200000;
		n_fail = n_fail + 1;
		final_report;
	end
endmodule
